// File: rtl/rsv_pkg.sv
package rsv_pkg;
	// Timing
	localparam int RSV_CLK_NS       = 5;
	localparam int RSV_TICK_NS      = 1000;
	localparam int RSV_TICK_CYC     = (RSV_TICK_NS + RSV_CLK_NS - 1) / RSV_CLK_NS;
	localparam int RSV_DLY_US       = 500;
	localparam int RSV_LDO_SS_US    = 160;
	localparam int RSV_BUCK_SS_US   = 500;
	localparam int RSV_FAULT_MS     = 100;
	localparam int RSV_FAULT_US     = RSV_FAULT_MS * 1000;
	localparam int RSV_CNT_W        = 17;
	localparam int RSV_DIV_W        = 8;

	// Rail index in sequence order
	localparam int RSV_NRAIL        = 5;
	localparam int RSV_R_LIN1       = 0;
	localparam int RSV_R_LIN2       = 1;
	localparam int RSV_R_SD2        = 2;
	localparam int RSV_R_SD1        = 3;
	localparam int RSV_R_SD3        = 4;
	localparam int RSV_IDX_W        = 3;
	localparam logic [RSV_IDX_W-1:0] RSV_IDX_LAST = 3'h4;
	localparam logic [RSV_NRAIL-1:0] RSV_DEEP_OFF = 5'h18;

	// Synchronised pin positions
	localparam int RSV_NPIN         = 6;
	localparam int RSV_P_UVOK       = 0;
	localparam int RSV_P_UVFLT      = 1;
	localparam int RSV_P_SEL2       = 2;
	localparam int RSV_P_SEL1       = 3;
	localparam int RSV_P_SEL3       = 4;
	localparam int RSV_P_DSLP       = 5;

	// APB map
	localparam int RSV_AW           = 8;
	localparam logic [RSV_AW-1:0] RSV_CTRL_OFS   = 8'h00;
	localparam logic [RSV_AW-1:0] RSV_STATUS_OFS = 8'h04;
	localparam logic [RSV_AW-1:0] RSV_ADDR_OFS   = 8'h08;
	localparam int RSV_CTRL_W       = 4;
	localparam logic [RSV_CTRL_W-1:0] RSV_CTRL_RST = 4'h0;
	localparam int RSV_C_SLEEP      = 0;
	localparam int RSV_C_SLEEP_SEL  = 1;
	localparam int RSV_C_DEEP       = 2;
	localparam int RSV_C_DEEP_SEL   = 3;

	// Serial bus address
	localparam logic [6:0] RSV_I2C_ADDR = 7'h25;
	localparam logic [7:0] RSV_I2C_WR   = {RSV_I2C_ADDR, 1'b0};
	localparam logic [7:0] RSV_I2C_RD   = {RSV_I2C_ADDR, 1'b1};

	typedef enum logic [2:0] {
		RSV_ST_OFF,
		RSV_ST_WAIT,
		RSV_ST_RAMP,
		RSV_ST_ON,
		RSV_ST_FAULT
	} rsv_state_t;
endpackage : rsv_pkg

// File: rtl/rsv_sequencer.sv
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module rsv_sequencer #(
	parameter int DLY_US     = rsv_pkg::RSV_DLY_US,
	parameter int LDO_SS_US  = rsv_pkg::RSV_LDO_SS_US,
	parameter int BUCK_SS_US = rsv_pkg::RSV_BUCK_SS_US,
	parameter int FAULT_US   = rsv_pkg::RSV_FAULT_US,
	parameter int TICK_CYC   = rsv_pkg::RSV_TICK_CYC
) (
	input  wire logic                          pclk,          // 200 MHz clock
	input  wire logic                          presetn,       // Async reset, low
	input  wire logic                          psel,          // APB select
	input  wire logic                          penable,       // APB access phase
	input  wire logic                          pwrite,        // APB write
	input  wire logic [rsv_pkg::RSV_AW-1:0]    paddr,         // APB byte address
	input  wire logic [31:0]                   pwdata,        // APB write data
	output logic      [31:0]                   prdata,        // APB read data
	output logic                               pready,        // APB ready
	output logic                               pslverr,       // APB error
	input  wire logic                          uv_ok_pin,     // input_undervoltage_ok
	input  wire logic                          uv_fault_pin,  // Rail undervoltage fault
	input  wire logic                          dvs_select_pin,         // step_down_two select
	input  wire logic                          rail1_select_pin,       // step_down_one select
	input  wire logic                          rail3_select_pin,       // step_down_three select
	input  wire logic                          deep_sleep_request_pin, // Deep sleep request
	output logic      [rsv_pkg::RSV_NRAIL-1:0] rail_en,       // Rail enables, sequence order
	output logic      [rsv_pkg::RSV_NRAIL-1:0] rail_good,     // Rail soft-start complete
	output logic                               sd1_vsel,      // 1: primary setting
	output logic                               sd2_vsel,      // 1: primary setting
	output logic                               sd3_vsel,      // 1: primary setting
	output logic                               sleep_mode,    // Sleep active
	output logic                               deep_sleep,    // Deep sleep active
	output logic                               interrupt_out_n // Fault indication, low
);
	import rsv_pkg::*;

	logic [RSV_NPIN-1:0]  sync1_q;
	logic [RSV_NPIN-1:0]  pin_q;
	rsv_state_t           state_q,   state_d;
	logic [RSV_IDX_W-1:0] idx_q,     idx_d;
	logic [RSV_CNT_W-1:0] cnt_q,     cnt_d;
	logic [RSV_DIV_W-1:0] div_q,     div_d;
	logic [RSV_NRAIL-1:0] seq_en_q,  seq_en_d;
	logic [RSV_NRAIL-1:0] good_q,    good_d;
	logic [RSV_NRAIL-1:0] en_q,      en_d;
	logic [RSV_CTRL_W-1:0] ctrl_q,   ctrl_d;
	logic [31:0]          rdata_q,   rdata_d;
	logic                 sel1_q,    sel1_d;
	logic                 sel2_q,    sel2_d;
	logic                 sel3_q,    sel3_d;
	logic                 irq_n_q,   irq_n_d;
	logic                 sleep_q,   sleep_d;
	logic                 deep_q,    deep_d;
	logic                 tick;
	logic                 deep_req;
	logic                 apb_setup;
	logic                 apb_wr;
	logic                 mapped;
	logic [RSV_CNT_W-1:0] ss_last;

	// Every pin is asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			pin_q   <= '0;
		end else begin
			sync1_q <= {deep_sleep_request_pin, rail3_select_pin, rail1_select_pin,
				dvs_select_pin, uv_fault_pin, uv_ok_pin};
			pin_q   <= sync1_q;
		end
	end

	assign tick     = (div_q == RSV_DIV_W'(TICK_CYC - 1));
	assign ss_last  = (idx_q <= RSV_IDX_W'(RSV_R_LIN2)) ? RSV_CNT_W'(LDO_SS_US - 1)
		: RSV_CNT_W'(BUCK_SS_US - 1);
	// pin or software bits request deep sleep
	assign deep_req = pin_q[RSV_P_DSLP] | (ctrl_q[RSV_C_DEEP] & ctrl_q[RSV_C_DEEP_SEL]);

	always_comb begin
		state_d  = state_q;
		idx_d    = idx_q;
		cnt_d    = cnt_q;
		seq_en_d = seq_en_q;
		good_d   = good_q;
		case (state_q)
			RSV_ST_OFF: begin
				seq_en_d = '0;
				good_d   = '0;
				if (pin_q[RSV_P_UVOK]) begin
					state_d     = RSV_ST_RAMP;
					idx_d       = '0;
					cnt_d       = '0;
					seq_en_d[0] = 1'b1;
				end
			end
			RSV_ST_WAIT: begin
				if (tick) begin
					if (cnt_q == RSV_CNT_W'(DLY_US - 1)) begin
						state_d         = RSV_ST_RAMP;
						cnt_d           = '0;
						seq_en_d[idx_q] = 1'b1;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
			end
			RSV_ST_RAMP: begin
				if (tick) begin
					if (cnt_q == ss_last) begin
						good_d[idx_q] = 1'b1;
						cnt_d         = '0;
						if (idx_q == RSV_IDX_LAST) begin
							state_d = RSV_ST_ON;
						end else begin
							state_d = RSV_ST_WAIT;
							idx_d   = idx_q + 1'b1;
						end
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
			end
			RSV_ST_ON: begin
			end
			RSV_ST_FAULT: begin
				// hold off 100 ms, then replay
				if (tick) begin
					if (cnt_q == RSV_CNT_W'(FAULT_US - 1)) begin
						state_d = RSV_ST_OFF;
						cnt_d   = '0;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
			end
			default: begin
				state_d = RSV_ST_OFF;
			end
		endcase
		if (state_q != RSV_ST_FAULT) begin
			if (pin_q[RSV_P_UVFLT]) begin
				state_d  = RSV_ST_FAULT;
				cnt_d    = '0;
				seq_en_d = '0;
				good_d   = '0;
			end else if (!pin_q[RSV_P_UVOK]) begin
				state_d  = RSV_ST_OFF;
				cnt_d    = '0;
				seq_en_d = '0;
				good_d   = '0;
			end
		end
		// Restart the divider so each wait is whole microseconds
		div_d = (state_d != state_q || tick) ? '0 : div_q + 1'b1;
	end

	always_comb begin
		deep_d  = (state_d == RSV_ST_ON) && deep_req;
		sleep_d = (state_d == RSV_ST_ON) && !deep_d
			&& ctrl_q[RSV_C_SLEEP] && ctrl_q[RSV_C_SLEEP_SEL];
		// deep sleep drops step_down_one and step_down_three
		en_d    = deep_d ? (seq_en_d & ~RSV_DEEP_OFF) : seq_en_d;
		// follows its pin at any time, forced primary in deep sleep
		sel2_d  = deep_d ? 1'b1 : pin_q[RSV_P_SEL2];
		// sample only while the rail is off; hold the sampled value while it is on
		sel1_d  = en_q[RSV_R_SD1] ? sel1_q : pin_q[RSV_P_SEL1];
		sel3_d  = en_q[RSV_R_SD3] ? sel3_q : pin_q[RSV_P_SEL3];
		irq_n_d = (state_d != RSV_ST_FAULT);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q  <= RSV_ST_OFF;
			idx_q    <= '0;
			cnt_q    <= '0;
			div_q    <= '0;
			seq_en_q <= '0;
			good_q   <= '0;
			en_q     <= '0;
			sel1_q   <= 1'b0;
			sel2_q   <= 1'b0;
			sel3_q   <= 1'b0;
			irq_n_q  <= 1'b1;
			sleep_q  <= 1'b0;
			deep_q   <= 1'b0;
		end else begin
			state_q  <= state_d;
			idx_q    <= idx_d;
			cnt_q    <= cnt_d;
			div_q    <= div_d;
			seq_en_q <= seq_en_d;
			good_q   <= good_d;
			en_q     <= en_d;
			sel1_q   <= sel1_d;
			sel2_q   <= sel2_d;
			sel3_q   <= sel3_d;
			irq_n_q  <= irq_n_d;
			sleep_q  <= sleep_d;
			deep_q   <= deep_d;
		end
	end

	// APB slave: zero wait states, read data prepared in the setup cycle
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;
	assign mapped    = (paddr == RSV_CTRL_OFS) || (paddr == RSV_STATUS_OFS)
		|| (paddr == RSV_ADDR_OFS);

	always_comb begin
		ctrl_d  = ctrl_q;
		rdata_d = rdata_q;
		if (apb_wr && paddr == RSV_CTRL_OFS) begin
			ctrl_d = pwdata[RSV_CTRL_W-1:0];
		end
		if (apb_setup) begin
			case (paddr)
				RSV_CTRL_OFS:   rdata_d = {28'h0000000, ctrl_q};
				RSV_STATUS_OFS: rdata_d = {8'h00, state_q, 3'h0, irq_n_q,
					deep_q, sleep_q, sel3_q, sel2_q, 1'b0, sel1_q, 1'b0,
					good_q, en_q};
				RSV_ADDR_OFS:   rdata_d = {16'h0000, RSV_I2C_RD, RSV_I2C_WR};
				default:        rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= RSV_CTRL_RST;
			rdata_q <= '0;
		end else begin
			ctrl_q  <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	assign prdata          = rdata_q;
	assign pready          = 1'b1;
	assign pslverr         = psel && penable && !mapped;
	assign rail_en         = en_q;
	assign rail_good       = good_q & en_q;
	assign sd1_vsel        = sel1_q;
	assign sd2_vsel        = sel2_q;
	assign sd3_vsel        = sel3_q;
	assign sleep_mode      = sleep_q;
	assign deep_sleep      = deep_q;
	assign interrupt_out_n = irq_n_q;

	sequence fault_seen;
		pin_q[RSV_P_UVFLT] && state_q != RSV_ST_FAULT;
	endsequence
	sequence rails_dark;
		rail_en == '0 && !interrupt_out_n;
	endsequence

	seq_order_a: assert property (@(posedge pclk) disable iff (!presetn)
		seq_en_q[RSV_NRAIL-1:1] == (seq_en_q[RSV_NRAIL-1:1] & seq_en_q[RSV_NRAIL-2:0]))
		else $error("rail enabled before its predecessor");
	first_rail_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == RSV_ST_OFF && pin_q[RSV_P_UVOK] && !pin_q[RSV_P_UVFLT]
		|=> seq_en_q[0] && state_q == RSV_ST_RAMP)
		else $error("first rail not started at once");
	ramp_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == RSV_ST_RAMP && tick && cnt_q == ss_last && pin_q[RSV_P_UVOK]
		&& !pin_q[RSV_P_UVFLT] |=> good_q[$past(idx_q)])
		else $error("rail not good at end of ramp");
	deep_rails_a: assert property (@(posedge pclk) disable iff (!presetn)
		deep_sleep |-> !rail_en[RSV_R_SD1] && !rail_en[RSV_R_SD3] && sd2_vsel)
		else $error("deep sleep rails wrong");
	sleep_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_mode |-> rail_en == '1)
		else $error("rail off in sleep");
	sleep_src_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sleep_mode) |-> $past(ctrl_q[RSV_C_SLEEP] && ctrl_q[RSV_C_SLEEP_SEL]))
		else $error("sleep without software bits");
	deep_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == RSV_ST_ON && pin_q[RSV_P_DSLP] && !pin_q[RSV_P_UVFLT]
		&& pin_q[RSV_P_UVOK] |=> deep_sleep)
		else $error("deep sleep pin ignored");
	sel2_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		!deep_d |=> sd2_vsel == $past(pin_q[RSV_P_SEL2]))
		else $error("step_down_two select not followed");
	sel1_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		rail_en[RSV_R_SD1] && $past(rail_en[RSV_R_SD1]) |-> $stable(sd1_vsel))
		else $error("step_down_one select moved while on");
	sel3_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		rail_en[RSV_R_SD3] && $past(rail_en[RSV_R_SD3]) |-> $stable(sd3_vsel))
		else $error("step_down_three select moved while on");
	fault_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		fault_seen |=> rails_dark ##1 rails_dark)
		else $error("fault did not shut rails");
	uv_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
		!pin_q[RSV_P_UVOK] && state_q != RSV_ST_FAULT |=> state_q != RSV_ST_ON
		&& rail_en == '0)
		else $error("chain not restarted on input loss");
endmodule : rsv_sequencer

// File: sim/rsv_host_model.sv
`timescale 1ns/100ps
module rsv_host_model (
	input  wire logic                         pclk,    // Clock
	input  wire logic                         presetn, // Reset, low
	input  wire logic [rsv_pkg::RSV_NPIN-1:0] want,    // Levels the host wants
	input  wire logic [rsv_pkg::RSV_NRAIL-1:0] rail_en, // Rail enables seen
	output logic      [rsv_pkg::RSV_NPIN-1:0] pins     // Pin levels driven
);
	import rsv_pkg::*;
	logic [RSV_NPIN-1:0] pins_d;
	always_comb begin
		pins_d = want;
		if (rail_en[RSV_R_SD1]) begin
			pins_d[RSV_P_SEL1] = pins[RSV_P_SEL1];
		end
		if (rail_en[RSV_R_SD3]) begin
			pins_d[RSV_P_SEL3] = pins[RSV_P_SEL3];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins <= 6'h00;
		end else begin
			pins <= pins_d;
		end
	end
endmodule : rsv_host_model

// File: sim/rail_sequencer_voltage_select_test.sv
`timescale 1ns/100ps
module rail_sequencer_voltage_select_test;
	import rsv_pkg::*;
	localparam int TK = 4;
	localparam int DL = 3;
	localparam int LS = 2;
	localparam int BS = 3;
	localparam int FU = 5;
	// Edges from a want change until the monitor sees it: host, two sync, state, monitor
	localparam int PIPE = 5;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  want, pins;
	logic [4:0]  rail_en, rail_good, en_p, gd_p;
	logic        b1v, b2v, b3v, slp, dslp, irq_n;
	int          fails, comparisons, cyc;
	int          t_en[5];
	int          t_gd[5];

	rsv_sequencer #(.DLY_US(DL), .LDO_SS_US(LS), .BUCK_SS_US(BS), .FAULT_US(FU),
		.TICK_CYC(TK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.uv_ok_pin(pins[RSV_P_UVOK]), .uv_fault_pin(pins[RSV_P_UVFLT]),
		.dvs_select_pin(pins[RSV_P_SEL2]), .rail1_select_pin(pins[RSV_P_SEL1]),
		.rail3_select_pin(pins[RSV_P_SEL3]), .deep_sleep_request_pin(pins[RSV_P_DSLP]),
		.rail_en(rail_en), .rail_good(rail_good), .sd1_vsel(b1v), .sd2_vsel(b2v),
		.sd3_vsel(b3v), .sleep_mode(slp), .deep_sleep(dslp), .interrupt_out_n(irq_n));
	rsv_host_model host (.pclk(pclk), .presetn(presetn), .want(want), .rail_en(rail_en),
		.pins(pins));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// Rise times of every enable and power-good bit
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		en_p <= rail_en;
		gd_p <= rail_good;
		for (int k = 0; k < 5; k++) begin
			if (rail_en[k] && !en_p[k]) t_en[k] = cyc;
			if (rail_good[k] && !gd_p[k]) t_gd[k] = cyc;
		end
	end

	task automatic close_out;
		$display("counts: %0d comparisons, %0d mismatches", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a hang here
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Whole chain must come up; every span after the first enable is a whole number of ticks
	task automatic check_seq(input int t0, input int d0);
		int n;
		n = 0;
		while (rail_good !== 5'h1F && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		// Let the rise monitor record the last power-good edge first
		@(posedge pclk);
		chk("chain complete", rail_good, 5'h1F);
		chk("first rail delay", t_en[0] - t0, d0);
		for (int k = 0; k < 5; k++) begin
			chk("soft start", t_gd[k] - t_en[k], (k < 2 ? LS : BS) * TK);
			if (k > 0) begin
				chk("start gap", t_en[k] - t_en[k-1], ((k < 3 ? LS : BS) + DL) * TK);
			end
		end
	endtask : check_seq

	task automatic t_idle;
		apb(1'b0, RSV_CTRL_OFS, 32'h0);
		chk("ctrl reset", rd, 32'h0);
		apb(1'b0, RSV_ADDR_OFS, 32'h0);
		chk("bus address bytes", rd[15:0], 16'h4B4A);
		apb(1'b0, 8'hFC, 32'h0);
		chk("unmapped error", err, 1'b1);
		chk("rails off", rail_en, 5'h00);
		chk("irq idle", irq_n, 1'b1);
		$display("done idle");
	endtask : t_idle
	task automatic t_seq;
		int t0;
		want[RSV_P_SEL3] <= 1'b1;
		want[RSV_P_SEL2] <= 1'b1;
		wt(8);
		t0 = cyc;
		want[RSV_P_UVOK] <= 1'b1;
		check_seq(t0, PIPE);
		apb(1'b0, RSV_STATUS_OFS, 32'h0);
		chk("status word", rd, 32'h006263FF);
		chk("mapped no error", err, 1'b0);
		chk("rail1 alternate", b1v, 1'b0);
		chk("rail3 primary", b3v, 1'b1);
		want[RSV_P_SEL1] <= 1'b1;
		want[RSV_P_SEL3] <= 1'b0;
		$display("done sequence");
	endtask : t_seq
	task automatic t_vscale;
		for (int v = 0; v < 2; v++) begin
			want[RSV_P_SEL2] <= v[0];
			wt(8);
			chk("rail2 select follow", b2v, v[0]);
			chk("rail2 stays on", rail_en, 5'h1F);
		end
		$display("done voltage select");
	endtask : t_vscale
	task automatic t_sleep;
		apb(1'b1, RSV_CTRL_OFS, 32'h3);
		wt(4);
		chk("sleep entered", slp, 1'b1);
		chk("sleep rails", rail_en, 5'h1F);
		apb(1'b1, RSV_CTRL_OFS, 32'h0);
		wt(4);
		chk("sleep left", slp, 1'b0);
		$display("done sleep");
	endtask : t_sleep
	task automatic t_deep;
		want[RSV_P_SEL2] <= 1'b0;
		for (int m = 0; m < 2; m++) begin
			if (m == 0) want[RSV_P_DSLP] <= 1'b1;
			else apb(1'b1, RSV_CTRL_OFS, 32'hC);
			wt(8);
			chk("deep entered", dslp, 1'b1);
			chk("deep rails", rail_en, 5'h07);
			chk("deep rail2 primary", b2v, 1'b1);
			if (m == 0) want[RSV_P_DSLP] <= 1'b0;
			else apb(1'b1, RSV_CTRL_OFS, 32'h0);
			wt(8);
			chk("deep left rails", rail_en, 5'h1F);
			chk("deep left dvs", b2v, 1'b0);
		end
		$display("done deep sleep");
	endtask : t_deep
	task automatic t_fault;
		int n, t0;
		t0 = cyc;
		want[RSV_P_UVFLT] <= 1'b1;
		wt(8);
		chk("fault rails off", rail_en, 5'h00);
		chk("fault irq low", irq_n, 1'b0);
		want[RSV_P_UVFLT] <= 1'b0;
		n = 0;
		while (irq_n !== 1'b1 && n < 500) begin
			@(posedge pclk);
			n++;
		end
		chk("fault hold time", cyc - t0, FU * TK + PIPE);
		// Hold-off ends in OFF for one cycle, then the first rail starts
		check_seq(cyc, 1);
		$display("done fault");
	endtask : t_fault
	task automatic t_uvloss;
		int n, t0;
		want[RSV_P_UVOK] <= 1'b0;
		wt(6);
		chk("input loss rails off", rail_en, 5'h00);
		wt(4);
		t0 = cyc;
		want[RSV_P_UVOK] <= 1'b1;
		n = 0;
		while (rail_en === 5'h00 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		chk("restart first rail", rail_en, 5'h01);
		check_seq(t0, PIPE);
		chk("rail1 primary", b1v, 1'b1);
		chk("rail3 alternate", b3v, 1'b0);
		$display("done input loss");
	endtask : t_uvloss

	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		close_out;
	end
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		want = 6'h00;
		{fails, comparisons} = {32'h0, 32'h0};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_idle;
		t_seq;
		t_vscale;
		t_sleep;
		t_deep;
		t_fault;
		t_uvloss;
		close_out;
	end
endmodule : rail_sequencer_voltage_select_test
